// ---- rtl/dbg_regs_pkg.sv ----
// constants and carrier types for the debug port access register block
package dbg_regs_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // register offsets
   localparam logic [3:0] OFF_PHY_CONTROL_B        = 4'h3;
   localparam logic [3:0] OFF_KEY_STATUS           = 4'h7;
   localparam logic [3:0] OFF_SYSTEM_RESET_REQUEST = 4'h8;
   localparam logic [3:0] OFF_PORT_CLOCK_CONTROL   = 4'h9;
   localparam logic [3:0] OFF_SYSTEM_CONTROL       = 4'hA;
   localparam logic [3:0] OFF_SYSTEM_STATUS        = 4'hB;
   localparam logic [3:0] OFF_MEMORY_CHECK_STATUS  = 4'hC;

   // field positions
   localparam int unsigned BIT_NEGATIVE_ACK_DISABLE      = 4;
   localparam int unsigned BIT_CONTENTION_DETECT_DISABLE = 3;
   localparam int unsigned BIT_PORT_DISABLE              = 2;
   localparam int unsigned BIT_USER_ROW_KEY_ACTIVE       = 5;
   localparam int unsigned BIT_MEMORY_PROGRAM_KEY        = 4;
   localparam int unsigned BIT_FULL_ERASE_KEY            = 3;
   localparam int unsigned BIT_RESET_HELD                = 0;
   localparam int unsigned BIT_USER_ROW_DONE             = 1;
   localparam int unsigned BIT_SYSTEM_CLOCK_REQUEST      = 0;
   localparam int unsigned BIT_SYSTEM_RESET_ACTIVE       = 5;
   localparam int unsigned BIT_SYSTEM_ASLEEP             = 4;
   localparam int unsigned BIT_MEMORY_PROGRAM_READY      = 3;
   localparam int unsigned BIT_USER_ROW_PROGRAM_READY    = 2;
   localparam int unsigned BIT_DEVICE_LOCKED             = 0;

   // values
   localparam logic [7:0] SYSTEM_RESET_REQUEST_CODE = 8'h59;
   localparam logic [7:0] DATA_ZERO                 = 8'h00;

   typedef enum logic [1:0] {
      CLK_SEL_RESERVED = 2'b00,
      CLK_SEL_16MHZ    = 2'b01,
      CLK_SEL_8MHZ     = 2'b10,
      CLK_SEL_4MHZ     = 2'b11
   } port_clock_select_t;

   typedef enum logic [2:0] {
      CHECK_OFF     = 3'b000,
      CHECK_BUSY    = 3'b001,
      CHECK_PASS    = 3'b010,
      CHECK_FAIL    = 3'b100
   } memory_check_t;

   // register access request from the link layer
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [3:0]        addr;
      logic [7:0]        wdata;
   } reg_req_t;

   // system domain status inputs
   typedef struct packed {
      logic              in_reset;
      logic              asleep;
      logic              locked;
      logic              program_ready;
      logic              user_row_ready;
      logic              check_enabled;
      logic              check_done;
      logic              check_failed;
   } sys_status_t;

   // key activity events from the key decoder
   typedef struct packed {
      logic              user_row_key_set;
      logic              memory_program_key_set;
      logic              full_erase_key_set;
      logic              program_done;
      logic              erase_done;
   } key_events_t;
endpackage : dbg_regs_pkg

// ---- rtl/debug_port_access_regs.sv ----
// access layer control and status registers of the single-wire debug port
`timescale 1ns/100ps

// Notes on behaviour
// - nack disable suppresses reset-abort negative acknowledge
// - contention disable stops line collision detection
// - port disable resets port, configuration, keys
// - user row key bit mirrors key
// - program key bit clears after programming
// - erase key bit clears after erase
// - writing 0x59 holds system reset
// - other value releases held system reset
// - reset register reads held state bit zero
// - system reset leaves port logic untouched
// - clock select codes, default 4 MHz
// - user row done starts flash programming
// - user row done writable only with key
// - clock request bit keeps system clock on
// - clock request set on enable, cleared disable
// - reset active bit sticky, clears on read
// - asleep bit shows idle or deeper sleep
// - program ready bit; debugger resets after
// - user row ready bit; debugger writes done
// - locked bit until erase clears lock
// - memory check status one-hot encoded
// - registers reached only through the link
module debug_port_access_regs
   import dbg_regs_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // register access from the link instruction decoder only
   input  wire reg_req_t    req_i,
   output logic [7:0]       rdata_o,
   output logic             rvalid_o,
   // port enable events (fuse or high-voltage entry)
   input  wire logic        port_enable_i,
   // key decoder and system domain
   input  wire key_events_t key_i,
   input  wire sys_status_t sys_i,
   // controls toward the physical layer and system
   output logic             negative_ack_disable_o,
   output logic             contention_detect_disable_o,
   output logic             port_reset_o,
   output logic [1:0]       port_clock_select_o,
   output logic             system_reset_o,
   output logic             system_clock_request_o,
   output logic             user_row_done_o
);

   logic        negative_ack_disable;
   logic        contention_detect_disable;
   logic        user_row_key_active;
   logic        memory_program_key;
   logic        full_erase_key;
   logic        reset_held;
   port_clock_select_t port_clock_select;
   logic        system_clock_request;
   logic        system_reset_active;
   logic        port_reset;
   logic        user_row_done;
   logic [7:0]  next_rdata;

   logic wr_phy;
   logic wr_rst;
   logic wr_clk;
   logic wr_sys;
   logic rd_status;
   logic disable_now;

   // decode; only the link request port reaches these registers
   assign wr_phy    = req_i.wr && (req_i.addr == OFF_PHY_CONTROL_B);
   assign wr_rst    = req_i.wr && (req_i.addr == OFF_SYSTEM_RESET_REQUEST);
   assign wr_clk    = req_i.wr && (req_i.addr == OFF_PORT_CLOCK_CONTROL);
   assign wr_sys    = req_i.wr && (req_i.addr == OFF_SYSTEM_CONTROL);
   assign rd_status = req_i.rd && (req_i.addr == OFF_SYSTEM_STATUS);
   assign disable_now = wr_phy && req_i.wdata[BIT_PORT_DISABLE];

   // physical layer configuration; port disable wipes it
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         negative_ack_disable      <= 1'b0;
         contention_detect_disable <= 1'b0;
      end
      else if (disable_now)
      begin
         negative_ack_disable      <= 1'b0;
         contention_detect_disable <= 1'b0;
      end
      else if (wr_phy)
      begin
         negative_ack_disable      <= req_i.wdata[BIT_NEGATIVE_ACK_DISABLE];
         contention_detect_disable <= req_i.wdata[BIT_CONTENTION_DETECT_DISABLE];
      end
   end

   // one-cycle port reset pulse on disable
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         port_reset <= 1'b0;
      else
         port_reset <= disable_now;
   end

   // keys: set by decoder, cleared by disable; program and erase keys also by sequence end
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         user_row_key_active <= 1'b0;
         memory_program_key  <= 1'b0;
         full_erase_key      <= 1'b0;
      end
      else if (disable_now)
      begin
         user_row_key_active <= 1'b0;
         memory_program_key  <= 1'b0;
         full_erase_key      <= 1'b0;
      end
      else
      begin
         user_row_key_active <= user_row_key_active || key_i.user_row_key_set;
         // a fresh key wins over a done in the same cycle
         memory_program_key  <= key_i.memory_program_key_set ||
                                (memory_program_key && !key_i.program_done);
         full_erase_key      <= key_i.full_erase_key_set ||
                                (full_erase_key && !key_i.erase_done);
      end
   end

   // reset request; runs on the port reset only, not the system one
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reset_held <= 1'b0;
      else if (wr_rst)
         reset_held <= (req_i.wdata == SYSTEM_RESET_REQUEST_CODE);
   end

   // port clock select; reserved code written is ignored
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         port_clock_select <= CLK_SEL_4MHZ;
      else if (disable_now || port_enable_i)
         port_clock_select <= CLK_SEL_4MHZ;
      else if (wr_clk && (req_i.wdata[1:0] != CLK_SEL_RESERVED))
         port_clock_select <= port_clock_select_t'(req_i.wdata[1:0]);
   end

   // system clock request
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         system_clock_request <= 1'b0;
      else if (disable_now)
         system_clock_request <= 1'b0;
      else if (port_enable_i)
         system_clock_request <= 1'b1;
      else if (wr_sys)
         system_clock_request <= req_i.wdata[BIT_SYSTEM_CLOCK_REQUEST];
   end

   // user row done pulse, gated by the decoded key
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         user_row_done <= 1'b0;
      else
         user_row_done <= wr_sys && user_row_key_active && req_i.wdata[BIT_USER_ROW_DONE];
   end

   // sticky reset active; a reset seen during the clearing read still wins
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         system_reset_active <= 1'b0;
      else if (sys_i.in_reset || reset_held)
         system_reset_active <= 1'b1;
      else if (rd_status)
         system_reset_active <= 1'b0;
   end

   // read mux; unlisted offsets and reserved bits return zero
   always_comb
   begin
      next_rdata = DATA_ZERO;
      if (req_i.addr == OFF_PHY_CONTROL_B)
      begin
         next_rdata[BIT_NEGATIVE_ACK_DISABLE]      = negative_ack_disable;
         next_rdata[BIT_CONTENTION_DETECT_DISABLE] = contention_detect_disable;
      end
      else if (req_i.addr == OFF_KEY_STATUS)
      begin
         next_rdata[BIT_USER_ROW_KEY_ACTIVE] = user_row_key_active;
         next_rdata[BIT_MEMORY_PROGRAM_KEY]  = memory_program_key;
         next_rdata[BIT_FULL_ERASE_KEY]      = full_erase_key;
      end
      else if (req_i.addr == OFF_SYSTEM_RESET_REQUEST)
         next_rdata[BIT_RESET_HELD] = reset_held;
      else if (req_i.addr == OFF_PORT_CLOCK_CONTROL)
         next_rdata[1:0] = port_clock_select;
      else if (req_i.addr == OFF_SYSTEM_CONTROL)
         next_rdata[BIT_SYSTEM_CLOCK_REQUEST] = system_clock_request;
      else if (req_i.addr == OFF_SYSTEM_STATUS)
      begin
         next_rdata[BIT_SYSTEM_RESET_ACTIVE]    = system_reset_active || sys_i.in_reset || reset_held;
         next_rdata[BIT_SYSTEM_ASLEEP]          = sys_i.asleep;
         next_rdata[BIT_MEMORY_PROGRAM_READY]   = sys_i.program_ready;
         next_rdata[BIT_USER_ROW_PROGRAM_READY] = sys_i.user_row_ready;
         next_rdata[BIT_DEVICE_LOCKED]          = sys_i.locked;
      end
      else if (req_i.addr == OFF_MEMORY_CHECK_STATUS)
      begin
         // one-hot; a fail beats a pass if both are seen
         if (!sys_i.check_enabled)
            next_rdata[2:0] = CHECK_OFF;
         else if (!sys_i.check_done)
            next_rdata[2:0] = CHECK_BUSY;
         else if (sys_i.check_failed)
            next_rdata[2:0] = CHECK_FAIL;
         else
            next_rdata[2:0] = CHECK_PASS;
      end
   end

   // read data registered, valid one cycle after the read strobe
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_o  <= DATA_ZERO;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= req_i.rd;
         if (req_i.rd)
            rdata_o <= next_rdata;
      end
   end

   // output registers
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         negative_ack_disable_o      <= 1'b0;
         contention_detect_disable_o <= 1'b0;
         port_reset_o                <= 1'b0;
         port_clock_select_o         <= CLK_SEL_4MHZ;
         system_reset_o              <= 1'b0;
         system_clock_request_o      <= 1'b0;
         user_row_done_o             <= 1'b0;
      end
      else
      begin
         negative_ack_disable_o      <= negative_ack_disable;
         contention_detect_disable_o <= contention_detect_disable;
         port_reset_o                <= port_reset;
         port_clock_select_o         <= port_clock_select;
         system_reset_o              <= reset_held;
         system_clock_request_o      <= system_clock_request;
         user_row_done_o             <= user_row_done;
      end
   end

endmodule : debug_port_access_regs

// ---- tb/debug_port_access_regs_bench.sv ----
// self-checking bench for the debug port access register block
`timescale 1ns/100ps
module debug_port_access_regs_bench;
   import dbg_regs_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   reg_req_t    req_i;
   logic [7:0]  rdata_o;
   logic        rvalid_o;
   logic        port_enable_i = 1'b0;
   key_events_t key_i = '0;
   sys_status_t sys_i = 8'h20;
   logic        nack_o, cont_o, prst_o, rst_o, creq_o, done_o;
   logic [1:0]  csel_o;
   int          num_errors = 0;
   int          tests_run = 0;
   int          m[16];
   int          ke[4] = '{8, 2, 4, 1};
   int          kx[4] = '{8'h30, 8'h20, 8'h28, 8'h20};
   int          da[4] = '{3, 7, 9, 10};
   logic [7:0]  d;
   sys_status_t s;
   always #25 clk_i = ~clk_i;
   debugger_model #(.BROWNOUT_HIGHEST(1'b1)) debugger_model_inst (.clk_i, .req_o(req_i), .rdata_i(rdata_o),
      .rvalid_i(rvalid_o));
   debug_port_access_regs debug_port_access_regs_inst (.clk_i, .rst_n_i, .req_i, .rdata_o, .rvalid_o,
      .port_enable_i, .key_i, .sys_i, .negative_ack_disable_o(nack_o), .contention_detect_disable_o(cont_o),
      .port_reset_o(prst_o), .port_clock_select_o(csel_o), .system_reset_o(rst_o),
      .system_clock_request_o(creq_o), .user_row_done_o(done_o));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rr(input logic [3:0] a);
      debugger_model_inst.rd(a, d);
      chk(d, m[a][7:0]);
   endtask : rr
   // output flops land one edge after the register
   task automatic settle;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask : settle
   task automatic ev(input logic [4:0] k, input logic en);
      @(posedge clk_i);
      key_i <= k;
      port_enable_i <= en;
      @(posedge clk_i);
      key_i <= '0;
      port_enable_i <= 1'b0;
   endtask : ev
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      test_done;
   end
   initial
   begin
      d = 8'($urandom(32'hAFB60FB3));
      m = '{default: 0};
      m[9] = 3;
      m[11] = 1;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 16; a++)
         rr(a[3:0]);
      chk(csel_o, 8'h03);
      $display("reset values done");
      repeat (6)
      begin
         d = 8'($urandom) & 8'hFB;
         debugger_model_inst.wr(OFF_PHY_CONTROL_B, d);
         m[3] = d & 8'h18;
         settle;
         chk({nack_o, cont_o}, d[4:3]);
         rr(OFF_PHY_CONTROL_B);
      end
      debugger_model_inst.wr(OFF_PHY_CONTROL_B, 8'h18);
      m[3] = 8'h18;
      debugger_model_inst.wr(OFF_SYSTEM_RESET_REQUEST, SYSTEM_RESET_REQUEST_CODE);
      settle;
      chk(rst_o, 8'h01);
      chk({nack_o, cont_o}, 8'h03);
      m[8] = 1;
      rr(OFF_SYSTEM_RESET_REQUEST);
      m[11] = 8'h21;
      rr(OFF_SYSTEM_STATUS);
      d = 8'($urandom);
      debugger_model_inst.wr(OFF_SYSTEM_RESET_REQUEST, d == 8'h59 ? 8'h00 : d);
      settle;
      chk(rst_o, 8'h00);
      m[8] = 0;
      rr(OFF_SYSTEM_RESET_REQUEST);
      @(posedge clk_i);
      sys_i.in_reset <= 1'b1;
      @(posedge clk_i);
      sys_i.in_reset <= 1'b0;
      rr(OFF_SYSTEM_STATUS);
      m[11] = 1;
      rr(OFF_SYSTEM_STATUS);
      $display("system reset done");
      for (int v = 3; v >= 0; v--)
      begin
         debugger_model_inst.set_clock(v[1:0]);
         if (v != 0)
            m[9] = v;
         settle;
         chk(csel_o, m[9][7:0]);
         rr(OFF_PORT_CLOCK_CONTROL);
      end
      debugger_model_inst.wr(OFF_SYSTEM_CONTROL, 8'h02);
      settle;
      chk(done_o, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         ev(ke[i][4:0] | (i == 0 ? 5'h10 : 5'h00), 1'b0);
         m[7] = kx[i];
         rr(OFF_KEY_STATUS);
      end
      debugger_model_inst.wr(OFF_SYSTEM_CONTROL, 8'h03);
      settle;
      chk({done_o, creq_o}, 8'h03);
      m[10] = 1;
      rr(OFF_SYSTEM_CONTROL);
      debugger_model_inst.wr(OFF_SYSTEM_CONTROL, 8'h00);
      settle;
      chk(creq_o, 8'h00);
      ev(5'h00, 1'b1);
      settle;
      chk({creq_o, csel_o}, 8'h07);
      debugger_model_inst.set_clock(2'h2);
      debugger_model_inst.wr(OFF_PHY_CONTROL_B, 8'h1C);
      settle;
      chk({prst_o, creq_o, nack_o, cont_o, csel_o}, 8'h23);
      m[3] = 0;
      m[7] = 0;
      m[9] = 3;
      m[10] = 0;
      foreach (da[i])
         rr(da[i][3:0]);
      $display("control and keys done");
      repeat (16)
      begin
         s = 8'($urandom) & 8'h7F;
         @(posedge clk_i);
         sys_i <= s;
         m[11] = {s.asleep, s.program_ready, s.user_row_ready, 1'b0, s.locked};
         m[12] = !s.check_enabled ? 0 : !s.check_done ? 1 : s.check_failed ? 4 : 2;
         rr(OFF_SYSTEM_STATUS);
         rr(OFF_MEMORY_CHECK_STATUS);
      end
      $display("status done");
      test_done;
   end
endmodule : debug_port_access_regs_bench

// ---- tb/debug_port_access_regs_properties.sv ----
// port-level assertions for the debug port access register block
`timescale 1ns/100ps
module debug_port_access_regs_properties
   import dbg_regs_pkg::*;
(
   // clock, reset and requests
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire reg_req_t    req_i,
   input wire logic        port_enable_i,
   input wire key_events_t key_i,
   input wire sys_status_t sys_i,
   // answers and controls
   input wire logic [7:0]  rdata_o,
   input wire logic        rvalid_o,
   input wire logic        negative_ack_disable_o,
   input wire logic        contention_detect_disable_o,
   input wire logic        port_reset_o,
   input wire logic [1:0]  port_clock_select_o,
   input wire logic        system_reset_o,
   input wire logic        system_clock_request_o,
   input wire logic        user_row_done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic phy_wr = req_i.wr && req_i.addr == OFF_PHY_CONTROL_B;
   wire logic rst_wr = req_i.wr && req_i.addr == OFF_SYSTEM_RESET_REQUEST;
   wire logic ctl_wr = req_i.wr && req_i.addr == OFF_SYSTEM_CONTROL;
   property p_answer; rvalid_o == $past(req_i.rd); endproperty
   a_answer: assert property (p_answer) else $error("read answer timing wrong");
   property p_phy; phy_wr && !req_i.wdata[2] |-> ##2 {negative_ack_disable_o, contention_detect_disable_o}
      == $past(req_i.wdata[4:3], 2); endproperty
   a_phy: assert property (p_phy) else $error("phy disables differ from write");
   property p_hold; rst_wr && req_i.wdata == SYSTEM_RESET_REQUEST_CODE |-> ##2 system_reset_o; endproperty
   a_hold: assert property (p_hold) else $error("system reset not held");
   property p_release; rst_wr && req_i.wdata != SYSTEM_RESET_REQUEST_CODE |-> ##2 !system_reset_o; endproperty
   a_release: assert property (p_release) else $error("system reset not released");
   property p_rst_read; req_i.rd && req_i.addr == OFF_SYSTEM_RESET_REQUEST |=> rdata_o[7:1] == 7'h00; endproperty
   a_rst_read: assert property (p_rst_read) else $error("reset register upper bits set");
   property p_sel; port_clock_select_o != CLK_SEL_RESERVED; endproperty
   a_sel: assert property (p_sel) else $error("reserved clock select");
   property p_disable; phy_wr && req_i.wdata[2] |-> ##2 port_reset_o && !system_clock_request_o
      && port_clock_select_o == 2'h3 ##1 !port_reset_o; endproperty
   a_disable: assert property (p_disable) else $error("port disable effects missing");
   property p_enable; port_enable_i |-> ##[1:2] system_clock_request_o; endproperty
   a_enable: assert property (p_enable) else $error("enable left clock request low");
   property p_creq; ctl_wr |-> ##2 system_clock_request_o == $past(req_i.wdata[0], 2); endproperty
   a_creq: assert property (p_creq) else $error("clock request differs from write");
   property p_done; $rose(user_row_done_o) |-> $past(ctl_wr, 2) && $past(req_i.wdata[1], 2) ##1 !user_row_done_o;
   endproperty
   a_done: assert property (p_done) else $error("user row done without write");
   c_hold: cover property (system_reset_o);
   c_disable: cover property (port_reset_o);
   c_done: cover property (user_row_done_o);
endmodule : debug_port_access_regs_properties

bind debug_port_access_regs debug_port_access_regs_properties debug_port_access_regs_properties_inst (.clk_i,
   .rst_n_i, .req_i, .port_enable_i, .key_i, .sys_i, .rdata_o, .rvalid_o, .negative_ack_disable_o,
   .contention_detect_disable_o, .port_reset_o, .port_clock_select_o, .system_reset_o,
   .system_clock_request_o, .user_row_done_o);

// ---- tb/debugger_model.sv ----
// behavioural debugger issuing register requests over the link
`timescale 1ns/100ps
module debugger_model
   import dbg_regs_pkg::*;
#(
   parameter bit BROWNOUT_HIGHEST = 1'b0
)
(
   // clock
   input  wire logic       clk_i,
   // requests and answers
   output reg_req_t        req_o,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i
);
   initial req_o = '0;
   // idle fields show the inverse so stale values never look valid
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b1, a, 8'hFF};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, 8'h00};
      @(negedge clk_i);
      d = rvalid_i ? rdata_i : 8'hXX;
   endtask : rd
   // faster port clocks only with the brownout detector at its top level
   task automatic set_clock(input logic [1:0] s);
      wr(OFF_PORT_CLOCK_CONTROL, {6'h00, BROWNOUT_HIGHEST ? s : 2'h3});
   endtask : set_clock
endmodule : debugger_model
